// [src/rtc_ctl_pkg.sv]
// Constants and carrier types for the clock interrupt and power-on block
// What this block does
// - Update end sets update-ended flag; with its enable, summary flag and interrupt line.
// - Host bus reset or reading the flag register clears the update-ended flag.
// - Low four bits of the flag register read zero and ignore writes.
// - Validity bit 7 set only by reading it, zero on low battery; bit 6 zero.
// - Date alarm bits writable outside update cycles, read zero if disabled, kept over bus reset.
// - Validity register bits 6..0 inaccessible while an update cycle runs.
// - Power-on control register clears only on battery reset, otherwise retained.
// - Alarm-remember: alarm passed without trickle supply powers up when trickle returns.
// - Stay-off bit floats the power-on output at trickle supply power-on.
// - Power-up bit drives the power-on output low at trickle supply power-on.
// - Power-on control bits 3..6 read zero and ignore writes.
// - Power-on control bit 7 drives crystal load select, 0 large, 1 small.
// - General purpose RAM in the first bank only, always accessible, even during updates.
// - Every interrupt source sets its flag whatever its enable.
// - Flag read returns a stable snapshot, clears read ones, holds new events.
// - Enabling an already set flag asserts the interrupt line at once.
// - Interrupt low while any flag and enable pair set; summary flag mirrors it.
// - Binary divider makes the 1 Hz tick; first update half second after release.
// - Periodic rate chosen by rate select; line assertion gated by its enable.
// - Falling button or enabled wake input turns main supply on.
// - Writing watchdog power control with bit 7 set turns main supply off.
// - Rate select picks one of thirteen taps; zero disables periodic events.
// - Alarm flag once per second while time equals alarm; top bits 11 match anything.
// - Host bus reset or freeze bit rising clears the update-ended enable.
// - Divider select codes hold the divider reset or run it normally.
package rtc_ctl_pkg;

  localparam int unsigned CLK_HZ      = 250_000_000;
  localparam int unsigned OSC_HZ      = 32_768;
  localparam int unsigned OSC_DIV_DEF = CLK_HZ / OSC_HZ;

  localparam logic [8:0] ADDR_SECONDS  = 9'h000;
  localparam logic [8:0] ADDR_SEC_ALM  = 9'h001;
  localparam logic [8:0] ADDR_MINUTES  = 9'h002;
  localparam logic [8:0] ADDR_MIN_ALM  = 9'h003;
  localparam logic [8:0] ADDR_HOURS    = 9'h004;
  localparam logic [8:0] ADDR_HOUR_ALM = 9'h005;
  localparam logic [8:0] ADDR_DATE     = 9'h007;
  localparam logic [8:0] ADDR_CTRL_A   = 9'h00a;
  localparam logic [8:0] ADDR_CTRL_B   = 9'h00b;
  localparam logic [8:0] ADDR_FLAGS    = 9'h00c;
  localparam logic [8:0] ADDR_VALID    = 9'h00d;
  localparam logic [8:0] ADDR_PWR_CTL  = 9'h07e;
  localparam logic [8:0] ADDR_WDOG     = 9'h100;
  localparam logic [8:0] ADDR_WAKE_EN  = 9'h101;
  localparam logic [8:0] ADDR_DATE_EN  = 9'h102;

  localparam int unsigned B_SET = 7;
  localparam int unsigned B_PIE = 6;
  localparam int unsigned B_AIE = 5;
  localparam int unsigned B_UIE = 4;
  localparam logic [7:0] B_WMASK = 8'hf6;

  localparam int unsigned P_REMEMBER = 0;
  localparam int unsigned P_STAY_OFF = 1;
  localparam int unsigned P_PWR_UP   = 2;
  localparam int unsigned P_XTAL     = 7;
  localparam logic [7:0] PCTL_WMASK  = 8'h87;
  localparam logic [7:0] PCTL_RST    = 8'h00;

  localparam int unsigned WDOG_OFF_BIT = 7;

  localparam logic [2:0] DV_NORMAL = 3'h2;
  localparam logic [2:0] DV_TEST   = 3'h3;
  localparam logic [6:0] REG_A_RST = 7'h20;

  localparam logic [14:0] DIV_HALF = 15'h4000;
  localparam logic [14:0] DIV_LAST = 15'h7fff;
  localparam logic [1:0]  DONT_CARE = 2'h3;

  typedef enum logic {UPD_IDLE = 1'b0, UPD_BUSY = 1'b1} upd_type;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

  typedef struct packed {
    logic [255:0][7:0] ram;
    logic [12:0]       pre;
    logic [14:0]       div;
    upd_type           upd;
    logic [6:0]        reg_a;
    logic [7:0]        reg_b;
    logic              pf;
    logic              af;
    logic              uf;
    logic [5:0]        date_alarm;
    logic              date_en;
    logic              valid;
    logic [7:0]        pctl;
    logic [7:0]        wake_en;
    logic              alarm_pending;
    logic              supply_n;
    logic              irq_n;
    logic [7:0]        rdata;
    logic [1:0]        hbr_s;
    logic [1:0]        trk_s;
    logic [1:0]        bat_s;
    logic [1:0]        btn_s;
    logic [7:0]        wake_s1;
    logic [7:0]        wake_s2;
    logic              trk_p;
    logic              btn_p;
    logic [7:0]        wake_p;
  } state_type;

endpackage

// [src/rtc_irq_power.sv]
// Clock interrupt flags, validity, power-on control and soft power flip-flop
module rtc_irq_power #(
  parameter int unsigned OSC_DIV = rtc_ctl_pkg::OSC_DIV_DEF
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     host_bus_reset,
  input  wire rtc_ctl_pkg::bus_req_type req,
  output logic [7:0]                    rdata,
  input  wire logic                     trickle_supply,
  input  wire logic                     battery_low,
  input  wire logic                     power_button_n,
  input  wire logic [7:0]               wake_event_inputs,
  output logic                          irq_out_n,
  output logic                          main_supply_on_n,
  output logic                          main_supply_on_n_oe_n,
  output logic                          crystal_load_select
);

  rtc_ctl_pkg::state_type s_q;
  rtc_ctl_pkg::state_type s_d;

  always_comb begin
    logic        osc_tick;
    logic        running;
    logic        wrap;
    logic        upd_end;
    logic        per_hit;
    logic        alarm_hit;
    logic        match;
    logic        hb_rst;
    logic        trk;
    logic        trk_rise;
    logic        btn_fall;
    logic        rd_flags;
    logic        rd_valid;
    logic        set_rise;
    logic        ram_sel;
    logic [2:0]  dv;
    logic [3:0]  rs;
    logic [3:0]  tap;
    logic [14:0] div_nx;
    logic [7:0]  wake_fall;
    logic [7:0]  rv;
    logic [7:0]  a_sec;
    logic [7:0]  a_min;
    logic [7:0]  a_hr;
    osc_tick  = 1'b0;
    running   = 1'b0;
    wrap      = 1'b0;
    upd_end   = 1'b0;
    per_hit   = 1'b0;
    alarm_hit = 1'b0;
    match     = 1'b0;
    hb_rst    = 1'b0;
    trk       = 1'b0;
    trk_rise  = 1'b0;
    btn_fall  = 1'b0;
    rd_flags  = 1'b0;
    rd_valid  = 1'b0;
    set_rise  = 1'b0;
    ram_sel   = 1'b0;
    dv        = 3'h0;
    rs        = 4'h0;
    tap       = 4'h0;
    div_nx    = 15'h0000;
    wake_fall = 8'h00;
    rv        = 8'h00;
    a_sec     = 8'h00;
    a_min     = 8'h00;
    a_hr      = 8'h00;
    s_d       = s_q;

    // Pins cross into clk through two flops before use
    s_d.hbr_s   = {s_q.hbr_s[0], host_bus_reset};
    s_d.trk_s   = {s_q.trk_s[0], trickle_supply};
    s_d.bat_s   = {s_q.bat_s[0], battery_low};
    s_d.btn_s   = {s_q.btn_s[0], power_button_n};
    s_d.wake_s1 = wake_event_inputs;
    s_d.wake_s2 = s_q.wake_s1;
    s_d.trk_p   = s_q.trk_s[1];
    s_d.btn_p   = s_q.btn_s[1];
    s_d.wake_p  = s_q.wake_s2;
    hb_rst      = s_q.hbr_s[1];
    trk         = s_q.trk_s[1];
    trk_rise    = trk & ~s_q.trk_p;
    btn_fall    = s_q.btn_p & ~s_q.btn_s[1];
    wake_fall   = s_q.wake_p & ~s_q.wake_s2 & s_q.wake_en;

    // Time base: one enable pulse per 32.768 kHz period, fraction dropped
    if (32'(s_q.pre) >= OSC_DIV - 1) begin
      s_d.pre  = 13'h0000;
      osc_tick = 1'b1;
    end else begin
      s_d.pre = s_q.pre + 13'h0001;
    end

    // Test codes keep the chain running as in normal mode
    dv      = s_q.reg_a[6:4];
    running = (dv == rtc_ctl_pkg::DV_NORMAL) || (dv == rtc_ctl_pkg::DV_TEST) ||
              (dv[2:1] == 2'b10);
    div_nx  = s_q.div + 15'h0001;
    if (!running) begin
      // Preloading half scale puts the first wrap half a second after release
      s_d.div = rtc_ctl_pkg::DIV_HALF;
    end else if (osc_tick) begin
      s_d.div = div_nx;
    end
    wrap = running & osc_tick & (s_q.div == rtc_ctl_pkg::DIV_LAST);

    // Codes 1 and 2 alias codes 8 and 9
    rs = s_q.reg_a[3:0];
    case (rs)
      4'h1: tap = 4'h6;
      4'h2: tap = 4'h7;
      default: tap = rs - 4'h2;
    endcase
    per_hit = running & osc_tick & (rs != 4'h0) &
              s_q.div[tap] & ~div_nx[tap];

    // Update cycle lasts one time base period; freeze aborts it
    if (s_q.reg_b[rtc_ctl_pkg::B_SET]) begin
      s_d.upd = rtc_ctl_pkg::UPD_IDLE;
    end else begin
      case (s_q.upd)
        rtc_ctl_pkg::UPD_IDLE: begin
          if (wrap) begin
            s_d.upd = rtc_ctl_pkg::UPD_BUSY;
          end
        end
        rtc_ctl_pkg::UPD_BUSY: begin
          if (osc_tick) begin
            s_d.upd = rtc_ctl_pkg::UPD_IDLE;
            upd_end = 1'b1;
          end
        end
        default: s_d.upd = rtc_ctl_pkg::UPD_IDLE;
      endcase
    end

    // Alarm compare once per completed update
    a_sec = s_q.ram[rtc_ctl_pkg::ADDR_SEC_ALM[7:0]];
    a_min = s_q.ram[rtc_ctl_pkg::ADDR_MIN_ALM[7:0]];
    a_hr  = s_q.ram[rtc_ctl_pkg::ADDR_HOUR_ALM[7:0]];
    match = ((a_sec[7:6] == rtc_ctl_pkg::DONT_CARE) ||
             (a_sec == s_q.ram[rtc_ctl_pkg::ADDR_SECONDS[7:0]])) &&
            ((a_min[7:6] == rtc_ctl_pkg::DONT_CARE) ||
             (a_min == s_q.ram[rtc_ctl_pkg::ADDR_MINUTES[7:0]])) &&
            ((a_hr[7:6] == rtc_ctl_pkg::DONT_CARE) ||
             (a_hr == s_q.ram[rtc_ctl_pkg::ADDR_HOURS[7:0]])) &&
            (!s_q.date_en || (s_q.date_alarm[5:4] == rtc_ctl_pkg::DONT_CARE) ||
             ({2'b00, s_q.date_alarm} == s_q.ram[rtc_ctl_pkg::ADDR_DATE[7:0]]));
    alarm_hit = upd_end & match;

    // Register reads, data presented in the following cycle only
    rd_flags = req.rd & (req.addr == rtc_ctl_pkg::ADDR_FLAGS);
    rd_valid = req.rd & (req.addr == rtc_ctl_pkg::ADDR_VALID);
    ram_sel  = ~req.addr[8] &&
               (req.addr != rtc_ctl_pkg::ADDR_CTRL_A) &&
               (req.addr != rtc_ctl_pkg::ADDR_CTRL_B) &&
               (req.addr != rtc_ctl_pkg::ADDR_FLAGS) &&
               (req.addr != rtc_ctl_pkg::ADDR_VALID) &&
               (req.addr != rtc_ctl_pkg::ADDR_PWR_CTL);
    case (req.addr)
      rtc_ctl_pkg::ADDR_CTRL_A: rv = {s_q.upd == rtc_ctl_pkg::UPD_BUSY, s_q.reg_a};
      rtc_ctl_pkg::ADDR_CTRL_B: rv = s_q.reg_b;
      // Snapshot of held flags; events this cycle land after the read
      rtc_ctl_pkg::ADDR_FLAGS:  rv = {~s_q.irq_n, s_q.pf, s_q.af, s_q.uf, 4'h0};
      rtc_ctl_pkg::ADDR_VALID: begin
        if (s_q.upd == rtc_ctl_pkg::UPD_BUSY) begin
          rv = {s_q.valid, 7'h00};
        end else begin
          rv = {s_q.valid, 1'b0, s_q.date_en ? s_q.date_alarm : 6'h00};
        end
      end
      rtc_ctl_pkg::ADDR_PWR_CTL: rv = s_q.pctl;
      rtc_ctl_pkg::ADDR_WDOG:    rv = {7'h00, ~s_q.supply_n};
      rtc_ctl_pkg::ADDR_WAKE_EN: rv = s_q.wake_en;
      rtc_ctl_pkg::ADDR_DATE_EN: rv = {7'h00, s_q.date_en};
      default: rv = ram_sel ? s_q.ram[req.addr[7:0]] : 8'h00;
    endcase
    s_d.rdata = req.rd ? rv : 8'h00;

    // Clear-on-read loses nothing: a same-cycle event still sets
    s_d.pf = (s_q.pf & ~rd_flags) | per_hit;
    s_d.af = (s_q.af & ~rd_flags) | alarm_hit;
    s_d.uf = (s_q.uf & ~rd_flags) | upd_end;

    // Reading the validity register arms it; low battery overrides
    if (s_q.bat_s[1]) begin
      s_d.valid = 1'b0;
    end else if (rd_valid) begin
      s_d.valid = 1'b1;
    end

    // Register writes
    if (req.wr) begin
      case (req.addr)
        rtc_ctl_pkg::ADDR_CTRL_A: s_d.reg_a = req.wdata[6:0];
        rtc_ctl_pkg::ADDR_CTRL_B: begin
          s_d.reg_b = req.wdata & rtc_ctl_pkg::B_WMASK;
          set_rise  = req.wdata[rtc_ctl_pkg::B_SET] & ~s_q.reg_b[rtc_ctl_pkg::B_SET];
          if (set_rise) begin
            s_d.reg_b[rtc_ctl_pkg::B_UIE] = 1'b0;
          end
        end
        rtc_ctl_pkg::ADDR_FLAGS: s_d.uf = s_d.uf;
        rtc_ctl_pkg::ADDR_VALID: begin
          if (s_q.upd != rtc_ctl_pkg::UPD_BUSY) begin
            s_d.date_alarm = req.wdata[5:0];
          end
        end
        rtc_ctl_pkg::ADDR_PWR_CTL: s_d.pctl = req.wdata & rtc_ctl_pkg::PCTL_WMASK;
        rtc_ctl_pkg::ADDR_WAKE_EN: s_d.wake_en = req.wdata;
        rtc_ctl_pkg::ADDR_DATE_EN: s_d.date_en = req.wdata[0];
        default: begin
          if (ram_sel) begin
            s_d.ram[req.addr[7:0]] = req.wdata;
          end
        end
      endcase
    end

    // Bus reset clears flags and enables, never the date alarm
    if (hb_rst) begin
      s_d.pf = 1'b0;
      s_d.af = 1'b0;
      s_d.uf = 1'b0;
      s_d.reg_b[rtc_ctl_pkg::B_PIE] = 1'b0;
      s_d.reg_b[rtc_ctl_pkg::B_AIE] = 1'b0;
      s_d.reg_b[rtc_ctl_pkg::B_UIE] = 1'b0;
    end

    // Soft power flip-flop; remembers an alarm missed while trickle is down
    if (alarm_hit && !trk) begin
      s_d.alarm_pending = 1'b1;
    end
    if (req.wr && (req.addr == rtc_ctl_pkg::ADDR_WDOG) &&
        req.wdata[rtc_ctl_pkg::WDOG_OFF_BIT]) begin
      s_d.supply_n = 1'b1;
    end
    if (trk_rise) begin
      s_d.alarm_pending = 1'b0;
      if (s_q.pctl[rtc_ctl_pkg::P_PWR_UP]) begin
        s_d.supply_n = 1'b0;
      end else if (s_q.pctl[rtc_ctl_pkg::P_REMEMBER] && s_q.alarm_pending) begin
        s_d.supply_n = 1'b0;
      end else if (s_q.pctl[rtc_ctl_pkg::P_STAY_OFF]) begin
        s_d.supply_n = 1'b1;
      end
    end
    if (btn_fall || (wake_fall != 8'h00)) begin
      s_d.supply_n = 1'b0;
    end

    // Line follows flag and enable of the next state, so late enables act at once
    s_d.irq_n = ~((s_d.pf & s_d.reg_b[rtc_ctl_pkg::B_PIE]) |
                  (s_d.af & s_d.reg_b[rtc_ctl_pkg::B_AIE]) |
                  (s_d.uf & s_d.reg_b[rtc_ctl_pkg::B_UIE]));

    // Battery reset: the only event that clears power control; also resets power state
    if (!rst_n) begin
      s_d               = '0;
      s_d.div           = rtc_ctl_pkg::DIV_HALF;
      s_d.reg_a         = rtc_ctl_pkg::REG_A_RST;
      s_d.pctl          = rtc_ctl_pkg::PCTL_RST;
      s_d.supply_n      = 1'b1;
      s_d.irq_n         = 1'b1;
      s_d.btn_s         = 2'b11;
      s_d.btn_p         = 1'b1;
      s_d.wake_s1       = 8'hff;
      s_d.wake_s2       = 8'hff;
      s_d.wake_p        = 8'hff;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign rdata                 = s_q.rdata;
  assign irq_out_n             = s_q.irq_n;
  // Open drain: drive low when on, float when off
  assign main_supply_on_n      = s_q.supply_n;
  assign main_supply_on_n_oe_n = s_q.supply_n;
  assign crystal_load_select   = s_q.pctl[rtc_ctl_pkg::P_XTAL];

endmodule

// [test/rtc_irq_power_monitor.sv]
// Port-level checker for the clock interrupt and power-on block
module rtc_irq_power_monitor #(
  parameter int unsigned OSC_DIV = rtc_ctl_pkg::OSC_DIV_DEF
) (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire logic                     host_bus_reset,
  input wire rtc_ctl_pkg::bus_req_type req,
  input wire logic [7:0]               rdata,
  input wire logic                     trickle_supply,
  input wire logic                     battery_low,
  input wire logic                     power_button_n,
  input wire logic [7:0]               wake_event_inputs,
  input wire logic                     irq_out_n,
  input wire logic                     main_supply_on_n,
  input wire logic                     main_supply_on_n_oe_n,
  input wire logic                     crystal_load_select
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] wa_q;
  logic [7:0] wd_q;
  logic       ram_hit;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Last write kept so a later read of the same byte can be judged
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wa_q <= 9'h000;
      wd_q <= 8'h00;
    end else if (req.wr) begin
      wa_q <= req.addr;
      wd_q <= req.wdata;
    end
  end
  assign ram_hit = (wa_q >= 9'h00e && wa_q <= 9'h0ff && wa_q != 9'h07e);

  flags_low_zero_a: assert property (req.rd && req.addr == rtc_ctl_pkg::ADDR_FLAGS
    |=> rdata[3:0] == 4'h0) else $error("flag register low bits not zero");
  summary_mirror_a: assert property (req.rd && req.addr == rtc_ctl_pkg::ADDR_FLAGS
    |=> rdata[7] == !$past(irq_out_n)) else $error("summary flag differs from irq line");
  valid_bit6_a: assert property (req.rd && req.addr == rtc_ctl_pkg::ADDR_VALID
    |=> rdata[6] == 1'b0) else $error("validity bit 6 not zero");
  pctl_reserved_a: assert property (req.rd && req.addr == rtc_ctl_pkg::ADDR_PWR_CTL
    |=> rdata[6:3] == 4'h0) else $error("power control reserved bits not zero");
  xtal_follow_a: assert property (req.wr && req.addr == rtc_ctl_pkg::ADDR_PWR_CTL
    |=> crystal_load_select == $past(req.wdata[7])) else $error("crystal load not updated");
  ram_access_a: assert property (req.rd && req.addr == wa_q && ram_hit
    |=> rdata == $past(wd_q)) else $error("general purpose byte lost");
  oe_equal_a: assert property (main_supply_on_n_oe_n == main_supply_on_n)
    else $error("power-on enable differs from pin value");
  wdog_off_a: assert property (req.wr && req.addr == rtc_ctl_pkg::ADDR_WDOG && req.wdata[7]
    |-> ##[1:2] main_supply_on_n) else $error("software off did not release supply");
  button_on_a: assert property ($fell(power_button_n) |-> ##[1:5] !main_supply_on_n)
    else $error("button press did not turn supply on");
  reset_values_a: assert property ($rose(rst_n) |-> irq_out_n && main_supply_on_n
    && !crystal_load_select && rdata == 8'h00) else $error("outputs not at reset values");

  cover property (req.rd && req.addr == rtc_ctl_pkg::ADDR_FLAGS ##1 rdata[7]);
  cover property ($fell(main_supply_on_n));
  cover property ($fell(irq_out_n));
endmodule

bind rtc_irq_power rtc_irq_power_monitor #(.OSC_DIV(OSC_DIV)) rtc_irq_power_monitor_i (
  .clk(clk), .rst_n(rst_n), .host_bus_reset(host_bus_reset), .req(req), .rdata(rdata),
  .trickle_supply(trickle_supply), .battery_low(battery_low),
  .power_button_n(power_button_n), .wake_event_inputs(wake_event_inputs),
  .irq_out_n(irq_out_n), .main_supply_on_n(main_supply_on_n),
  .main_supply_on_n_oe_n(main_supply_on_n_oe_n), .crystal_load_select(crystal_load_select));

// [test/supply_model.sv]
// Main supply model: pulled-up power-on line, rail on while line is low
module supply_model (
  input  wire logic power_on_n,
  input  wire logic power_on_oe_n,
  output logic      rail_on
);
  timeunit 1ns;
  timeprecision 100ps;
  logic line_level;
  // Released line rises through the pull-up, never keeps the last value
  assign line_level = power_on_oe_n ? 1'b1 : power_on_n;
  assign rail_on    = !line_level;
endmodule

// [test/tb_top.sv]
// Self-checking bench for the clock interrupt and power-on block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                     clk, rst_n, host_bus_reset, trickle_supply, battery_low;
  logic                     power_button_n, irq_out_n, main_supply_on_n, rail_on;
  logic                     main_supply_on_n_oe_n, crystal_load_select;
  logic [7:0]               wake_event_inputs, rdata, v;
  rtc_ctl_pkg::bus_req_type req;
  int                       n_fail, cmp_count, n;
  logic [8:0]               ra [5] = '{9'h00e, 9'h07d, 9'h07f, 9'h080, 9'h0ff};

  // Short oscillator divide keeps a half second near 32768 cycles
  rtc_irq_power #(.OSC_DIV(2)) rtc_irq_power_i (
    .clk(clk), .rst_n(rst_n), .host_bus_reset(host_bus_reset), .req(req), .rdata(rdata),
    .trickle_supply(trickle_supply), .battery_low(battery_low),
    .power_button_n(power_button_n), .wake_event_inputs(wake_event_inputs),
    .irq_out_n(irq_out_n), .main_supply_on_n(main_supply_on_n),
    .main_supply_on_n_oe_n(main_supply_on_n_oe_n), .crystal_load_select(crystal_load_select));
  supply_model supply_model_i (.power_on_n(main_supply_on_n),
    .power_on_oe_n(main_supply_on_n_oe_n), .rail_on(rail_on));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a);
    @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  task automatic rc(input logic [8:0] a, input logic [7:0] e);
    rd(a);
    chk(v, e);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // A hang costs a mismatch; full run needs about 33000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    $display("Error at %0t: run did not finish", $time);
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    host_bus_reset = 1'b0;
    req = '0;
    trickle_supply = 1'b1;
    battery_low = 1'b0;
    power_button_n = 1'b1;
    wake_event_inputs = 8'hff;
    n_fail = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    chk(8'(irq_out_n), 8'h01);
    chk(8'(main_supply_on_n), 8'h01);
    rc(rtc_ctl_pkg::ADDR_PWR_CTL, 8'h00);
    wr(rtc_ctl_pkg::ADDR_PWR_CTL, 8'hf8);
    rc(rtc_ctl_pkg::ADDR_PWR_CTL, 8'h80);
    chk(8'(crystal_load_select), 8'h01);
    wr(rtc_ctl_pkg::ADDR_PWR_CTL, 8'h00);
    foreach (ra[i]) begin
      wr(ra[i], ra[i][7:0] ^ 8'h5a);
      rc(ra[i], ra[i][7:0] ^ 8'h5a);
    end
    wr(rtc_ctl_pkg::ADDR_FLAGS, 8'hff);
    rc(rtc_ctl_pkg::ADDR_FLAGS, 8'h00);
    $display("registers test done");
    // Fastest periodic rate, flag set with its enable still off
    wr(rtc_ctl_pkg::ADDR_CTRL_A, 8'h23);
    cyc(20);
    rc(rtc_ctl_pkg::ADDR_FLAGS, 8'h40);
    cyc(20);
    chk(8'(irq_out_n), 8'h01);
    wr(rtc_ctl_pkg::ADDR_CTRL_B, 8'h40);
    cyc(0);
    chk(8'(irq_out_n), 8'h00);
    rc(rtc_ctl_pkg::ADDR_FLAGS, 8'hc0);
    wr(rtc_ctl_pkg::ADDR_CTRL_A, 8'h20);
    rd(rtc_ctl_pkg::ADDR_FLAGS);
    rc(rtc_ctl_pkg::ADDR_FLAGS, 8'h00);
    cyc(1);
    chk(8'(irq_out_n), 8'h01);
    wr(rtc_ctl_pkg::ADDR_CTRL_B, 8'h00);
    $display("periodic test done");
    power_button_n <= 1'b0;
    cyc(6);
    chk(8'(rail_on), 8'h01);
    @(posedge clk) power_button_n <= 1'b1;
    wr(rtc_ctl_pkg::ADDR_WDOG, 8'h80);
    cyc(2);
    chk(8'(rail_on), 8'h00);
    wr(rtc_ctl_pkg::ADDR_WAKE_EN, 8'h01);
    wake_event_inputs <= 8'hfd;
    cyc(6);
    chk(8'(rail_on), 8'h00);
    @(posedge clk) wake_event_inputs <= 8'hfc;
    cyc(6);
    chk(8'(rail_on), 8'h01);
    @(posedge clk) wake_event_inputs <= 8'hff;
    wr(rtc_ctl_pkg::ADDR_WDOG, 8'h80);
    wr(rtc_ctl_pkg::ADDR_PWR_CTL, 8'h04);
    trickle_supply <= 1'b0;
    cyc(4);
    @(posedge clk) trickle_supply <= 1'b1;
    cyc(6);
    chk(8'(rail_on), 8'h01);
    // Supply is still on here, so the trickle reset must turn it off
    wr(rtc_ctl_pkg::ADDR_PWR_CTL, 8'h02);
    trickle_supply <= 1'b0;
    cyc(4);
    @(posedge clk) trickle_supply <= 1'b1;
    cyc(6);
    chk(8'(rail_on), 8'h00);
    $display("power test done");
    // Alarm with every byte don't-care falls due while trickle is gone
    wr(rtc_ctl_pkg::ADDR_PWR_CTL, 8'h01);
    wr(rtc_ctl_pkg::ADDR_SEC_ALM, 8'hc0);
    wr(rtc_ctl_pkg::ADDR_MIN_ALM, 8'hc0);
    wr(rtc_ctl_pkg::ADDR_HOUR_ALM, 8'hc0);
    wr(rtc_ctl_pkg::ADDR_CTRL_A, 8'h00);
    trickle_supply <= 1'b0;
    wr(rtc_ctl_pkg::ADDR_CTRL_B, 8'h10);
    wr(rtc_ctl_pkg::ADDR_CTRL_A, 8'h20);
    n = 0;
    while (irq_out_n !== 1'b0 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n >= 32760 && n <= 32790), 8'h01);
    rc(rtc_ctl_pkg::ADDR_FLAGS, 8'hb0);
    rc(rtc_ctl_pkg::ADDR_FLAGS, 8'h00);
    @(posedge clk) trickle_supply <= 1'b1;
    cyc(6);
    chk(8'(rail_on), 8'h01);
    $display("update test done");
    rd(rtc_ctl_pkg::ADDR_VALID);
    rc(rtc_ctl_pkg::ADDR_VALID, 8'h80);
    wr(rtc_ctl_pkg::ADDR_VALID, 8'h7f);
    rc(rtc_ctl_pkg::ADDR_VALID, 8'h80);
    wr(rtc_ctl_pkg::ADDR_DATE_EN, 8'h01);
    rc(rtc_ctl_pkg::ADDR_VALID, 8'hbf);
    wr(rtc_ctl_pkg::ADDR_CTRL_B, 8'h70);
    battery_low <= 1'b1;
    host_bus_reset <= 1'b1;
    cyc(4);
    @(posedge clk) host_bus_reset <= 1'b0;
    rc(rtc_ctl_pkg::ADDR_VALID, 8'h3f);
    rc(rtc_ctl_pkg::ADDR_CTRL_B, 8'h00);
    rc(rtc_ctl_pkg::ADDR_PWR_CTL, 8'h01);
    wr(rtc_ctl_pkg::ADDR_CTRL_B, 8'h10);
    wr(rtc_ctl_pkg::ADDR_CTRL_B, 8'h90);
    rc(rtc_ctl_pkg::ADDR_CTRL_B, 8'h80);
    rc(9'h1f0, 8'h00);
    $display("validity test done");
    end_of_test();
  end
endmodule
